/* pkg/comparator_pkg.sv */
// constants, field layout and edge modes of the comparator control block
package comparator_pkg;

    // register port geometry
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;

    // register map
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] WRITE_MASK = 8'hD7;
    localparam logic [7:0] READ_NONE = 8'h00;

    // field positions
    localparam int ENABLE_BIT = 7;
    localparam int BANDGAP_BIT = 6;
    localparam int FLAG_BIT = 5;
    localparam int IRQ_ENABLE_BIT = 4;
    localparam int LEVEL_BIT = 3;
    localparam int PIN_ENABLE_BIT = 2;
    localparam int MODE_HIGH = 1;
    localparam int MODE_LOW = 0;

    // enabled cycles before edges count: output lag, two sync flops and the previous-level flop
    localparam int ARM_STAGES = 4;

    // edge mode encodings
    typedef enum logic [1:0] {
        MODE_FALL_A = 2'h0,
        MODE_RISE = 2'h1,
        MODE_FALL_B = 2'h2,
        MODE_BOTH = 2'h3
    } edge_mode_type;

    function automatic logic wants_rise(input logic [1:0] mode);
        return (edge_mode_type'(mode) == MODE_RISE) ||
               (edge_mode_type'(mode) == MODE_BOTH);
    endfunction : wants_rise

    function automatic logic wants_fall(input logic [1:0] mode);
        return (edge_mode_type'(mode) == MODE_FALL_A) ||
               (edge_mode_type'(mode) == MODE_FALL_B) ||
               (edge_mode_type'(mode) == MODE_BOTH);
    endfunction : wants_fall

endpackage : comparator_pkg

/* pkg/edge_if.sv */
// signals between the control logic and the edge detector
`timescale 1ns/1ns
interface edge_if;
    logic active;
    logic [1:0] mode;
    logic level;
    logic eventPulse;

    modport detector (
        input active,
        input mode,
        output level,
        output eventPulse
    );
    modport control (
        input level,
        input eventPulse,
        output active,
        output mode
    );
endinterface : edge_if

/* verilog/compare_edge_detect.sv */
// synchroniser and edge detector for the raw comparator output
`timescale 1ns/1ns
module compare_edge_detect (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // asynchronous comparator output
    input wire logic compRaw,
    // control side
    edge_if.detector port
);
    logic syncFirst;
    logic syncSecond;
    logic prevLevel;
    logic [comparator_pkg::ARM_STAGES-1:0] armChain;

    // comparator output may lag enable by a cycle, then two sync flops and the previous-level flop
    wire logic [comparator_pkg::ARM_STAGES-1:0] next_armChain =
        port.active ? {armChain[comparator_pkg::ARM_STAGES-2:0], 1'b1} :
        {comparator_pkg::ARM_STAGES{1'b0}};

    // [RQ12] two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncFirst <= 1'b0;
            syncSecond <= 1'b0;
            prevLevel <= 1'b0;
            armChain <= {comparator_pkg::ARM_STAGES{1'b0}};
        end else begin
            syncFirst <= compRaw;
            syncSecond <= syncFirst;
            prevLevel <= syncSecond;
            armChain <= next_armChain;
        end
    end

    wire logic risingSeen = syncSecond & ~prevLevel;
    wire logic fallingSeen = ~syncSecond & prevLevel;
    // [RQ8] mode picks the edge kind
    wire logic wantedEdge =
        (risingSeen & comparator_pkg::wants_rise(port.mode)) |
        (fallingSeen & comparator_pkg::wants_fall(port.mode));

    // [RQ9] high means positive input above negative
    assign port.level = syncSecond;
    // [RQ12] armed once only enabled samples fill the synchroniser
    wire logic armed = armChain[comparator_pkg::ARM_STAGES-1];
    assign port.eventPulse = armed & port.active & wantedEdge;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sync_delay_a: assert property ( // [RQ12]
        $past(rst_n, 2) && $past(rst_n) |->
            port.level == $past(compRaw, 2))
        else $error("level is not the raw input two cycles late");
    arm_wait_a: assert property ( // [RQ12]
        port.eventPulse |-> $past(port.active, comparator_pkg::ARM_STAGES))
        else $error("edge flagged before the synchroniser settled");
    edge_armed_a: assert property ( // [RQ12]
        port.eventPulse |-> port.active && $past(port.active))
        else $error("edge flagged while module not enabled");
endmodule : compare_edge_detect

/* verilog/analog_comparator_control.sv */
// control, status and edge flag logic around an analog comparator
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// What this block does
// [RQ1] comparator works only while module enable bit 7 is set
// [RQ2] bit 6 selects positive pin when 0, bandgap reference when 1
// [RQ3] flag bit 5 sets on each transition chosen by the edge mode
// [RQ4] writing 1 to flag bit clears it; writing 0 leaves it
// [RQ5] with bit 4 set, interrupt request follows the flag
// [RQ6] bit 3 reads the comparator level, forced to 0 when disabled
// [RQ7] bit 2 drives the comparator level onto its output pin
// [RQ8] mode 00 falling, 01 rising, 10 falling, 11 either edge
// [RQ9] comparator output high when positive input exceeds negative
// [RQ10] comparator inactive in every stop mode, never a wake source
// [RQ11] leaving deepest stop, or stop by reset, gives reset state
// [RQ12] comparator output synchronised twice; edges seen only when enabled
module analog_comparator_control (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [comparator_pkg::ADDR_WIDTH-1:0] address,
    input wire logic [comparator_pkg::DATA_WIDTH-1:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [comparator_pkg::DATA_WIDTH-1:0] readData,
    // power management
    input wire logic stopMode,
    input wire logic powerDownExit,
    // analog comparator
    input wire logic compRaw,
    output logic compEnable,
    output logic bandgapSelect,
    // output pin
    output logic comparatorOutputPin,
    output logic pinOutEnable,
    // interrupt
    output logic interruptRequest
);

    logic [comparator_pkg::DATA_WIDTH-1:0] control;
    logic compareEventFlag;
    logic comparatorOutputLevel;

    edge_if edges();

    compare_edge_detect detector (
        .clock(clock),
        .rst_n(rst_n),
        .compRaw(compRaw),
        .port(edges.detector)
    );

    // register decode
    wire logic hit = address == comparator_pkg::CONTROL_OFFSET;
    wire logic writeHit = writeStrobe & hit;
    wire logic readHit = readStrobe & hit;

    // field views of the control register
    wire logic comparatorModuleEnable =
        control[comparator_pkg::ENABLE_BIT];
    wire logic bandgapInputSelect = control[comparator_pkg::BANDGAP_BIT];
    wire logic compareInterruptEnable =
        control[comparator_pkg::IRQ_ENABLE_BIT];
    wire logic outputPinEnable = control[comparator_pkg::PIN_ENABLE_BIT];
    wire logic [1:0] edgeModeSelect =
        control[comparator_pkg::MODE_HIGH:comparator_pkg::MODE_LOW];

    // [RQ1] enable bit gates the comparator
    // [RQ10] stop overrides the enable bit, whatever its prior setting
    wire logic active = comparatorModuleEnable & ~stopMode;
    assign edges.active = active;
    assign edges.mode = edgeModeSelect;

    // [RQ11] power-down exit restores reset values
    wire logic [comparator_pkg::DATA_WIDTH-1:0] next_control =
        powerDownExit ? comparator_pkg::CONTROL_RESET :
        writeHit ? (writeData & comparator_pkg::WRITE_MASK) : control;

    // [RQ4] write-one clear, zero leaves flag alone
    wire logic clearFlag = writeHit & writeData[comparator_pkg::FLAG_BIT];
    // [RQ3] a detected edge wins over a clear in the same cycle
    wire logic next_flag = ~powerDownExit &
        (edges.eventPulse | (compareEventFlag & ~clearFlag));

    wire logic next_active = next_control[comparator_pkg::ENABLE_BIT] &
        ~stopMode;
    // [RQ6] level reads 0 from the very cycle the module is disabled
    wire logic next_level = next_active & edges.level;
    wire logic next_pinEnable = next_active &
        next_control[comparator_pkg::PIN_ENABLE_BIT];
    // [RQ5] request tracks flag and enable, cycle for cycle
    wire logic next_irq = next_flag &
        next_control[comparator_pkg::IRQ_ENABLE_BIT];

    // read image: reserved bits none, flag and level from hardware
    wire logic [comparator_pkg::DATA_WIDTH-1:0] readValue = {
        comparatorModuleEnable,
        bandgapInputSelect,
        compareEventFlag,
        compareInterruptEnable,
        comparatorOutputLevel,
        outputPinEnable,
        edgeModeSelect
    };
    // unmapped reads answer zero
    wire logic [comparator_pkg::DATA_WIDTH-1:0] next_readData =
        readHit ? readValue : comparator_pkg::READ_NONE;

    // register state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control <= comparator_pkg::CONTROL_RESET;
            compareEventFlag <= 1'b0;
            comparatorOutputLevel <= 1'b0;
        end else begin
            control <= next_control;
            compareEventFlag <= next_flag;
            comparatorOutputLevel <= next_level;
        end
    end

    // outputs, all registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readData <= comparator_pkg::READ_NONE;
            compEnable <= 1'b0;
            bandgapSelect <= 1'b0;
            comparatorOutputPin <= 1'b0;
            pinOutEnable <= 1'b0;
            interruptRequest <= 1'b0;
        end else begin
            readData <= next_readData;
            // [RQ1] analog part powered only while active
            compEnable <= next_active;
            // [RQ2] positive input source select
            bandgapSelect <= next_control[comparator_pkg::BANDGAP_BIT];
            // [RQ7] pin carries the level only when enabled
            comparatorOutputPin <= next_pinEnable & edges.level;
            pinOutEnable <= next_pinEnable;
            interruptRequest <= next_irq;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    enable_gates_a: assert property ( // [RQ1]
        !comparatorModuleEnable |->
            !edges.eventPulse ##1 !compEnable || comparatorModuleEnable)
        else $error("comparator active while disabled");

    bandgap_select_a: assert property ( // [RQ2]
        writeHit && !powerDownExit |=>
            bandgapSelect == $past(writeData[comparator_pkg::BANDGAP_BIT]))
        else $error("bandgap select does not follow the write");

    flag_set_a: assert property ( // [RQ3]
        edges.eventPulse && !powerDownExit |=> compareEventFlag)
        else $error("edge event did not set the flag");

    flag_clear_a: assert property ( // [RQ4]
        compareEventFlag && clearFlag && !edges.eventPulse |=>
            !compareEventFlag)
        else $error("write of one did not clear the flag");

    flag_hold_a: assert property ( // [RQ4]
        compareEventFlag && writeHit && !powerDownExit &&
        !writeData[comparator_pkg::FLAG_BIT] |=> compareEventFlag)
        else $error("write of zero changed the flag");

    irq_follows_a: assert property ( // [RQ5]
        interruptRequest == (compareEventFlag && compareInterruptEnable))
        else $error("interrupt request differs from flag and enable");

    level_forced_a: assert property ( // [RQ6]
        readHit && !comparatorModuleEnable |=>
            !readData[comparator_pkg::LEVEL_BIT])
        else $error("level read as one while disabled");

    unmapped_read_a: assert property ( // [RQ6]
        readStrobe && !hit |=> readData == comparator_pkg::READ_NONE)
        else $error("unmapped read returned data");

    pin_gate_a: assert property ( // [RQ7]
        !outputPinEnable |-> !pinOutEnable && !comparatorOutputPin)
        else $error("pin driven while pin enable is clear");

    rise_mode_a: assert property ( // [RQ8]
        edges.eventPulse &&
        edgeModeSelect == comparator_pkg::MODE_RISE |->
            edges.level && !$past(edges.level))
        else $error("rising mode flagged a non-rising edge");

    fall_mode_a: assert property ( // [RQ8]
        edges.eventPulse && !edgeModeSelect[comparator_pkg::MODE_LOW] |->
            !edges.level && $past(edges.level))
        else $error("falling mode flagged a non-falling edge");

    stop_idle_a: assert property ( // [RQ10]
        stopMode |-> !edges.eventPulse ##1 !compEnable)
        else $error("comparator active during stop");

    wake_reset_a: assert property ( // [RQ11]
        powerDownExit |=> control == comparator_pkg::CONTROL_RESET &&
            !compareEventFlag && !interruptRequest)
        else $error("power-down exit did not restore reset state");

    // field level checks of the registers, the read image and the outputs
    read_enable_a: assert property ( // [RQ1]
        readHit |=> readData[comparator_pkg::ENABLE_BIT] ==
            $past(comparatorModuleEnable))
        else $error("enable bit read differs from the register");

    enable_out_a: assert property ( // [RQ1]
        compEnable |-> comparatorModuleEnable)
        else $error("comparator powered while enable bit is clear");

    bandgap_follow_a: assert property ( // [RQ2]
        bandgapSelect == bandgapInputSelect)
        else $error("input select output differs from its bit");

    flag_only_a: assert property ( // [RQ3]
        !compareEventFlag && !edges.eventPulse |=> !compareEventFlag)
        else $error("flag set without an edge event");

    set_wins_a: assert property ( // [RQ3]
        edges.eventPulse && clearFlag && !powerDownExit |=>
            compareEventFlag)
        else $error("clear beat a same-cycle edge event");

    read_flag_a: assert property ( // [RQ3]
        readHit |=> readData[comparator_pkg::FLAG_BIT] ==
            $past(compareEventFlag))
        else $error("flag bit read differs from the flag");

    write_mask_a: assert property ( // [RQ4]
        writeHit && !powerDownExit |=>
            control == ($past(writeData) & comparator_pkg::WRITE_MASK))
        else $error("write did not land through the mask");

    irq_off_a: assert property ( // [RQ5]
        !compareInterruptEnable |-> !interruptRequest)
        else $error("interrupt requested while disabled");

    level_gate_a: assert property ( // [RQ6]
        !comparatorModuleEnable |-> !comparatorOutputLevel)
        else $error("level bit held while module disabled");

    read_level_a: assert property ( // [RQ6]
        readHit |=> readData[comparator_pkg::LEVEL_BIT] ==
            $past(comparatorOutputLevel))
        else $error("level bit read differs from the level");

    read_idle_a: assert property ( // [RQ6]
        !readStrobe |=> readData == comparator_pkg::READ_NONE)
        else $error("read data stood outside its cycle");

    pin_level_a: assert property ( // [RQ7]
        pinOutEnable |-> comparatorOutputPin == $past(edges.level))
        else $error("output pin differs from the comparator level");

    both_mode_a: assert property ( // [RQ8]
        edges.eventPulse && edgeModeSelect == comparator_pkg::MODE_BOTH |->
            edges.level != $past(edges.level))
        else $error("either-edge mode flagged without a change");

    stop_output_a: assert property ( // [RQ10]
        stopMode |=> !compEnable && !pinOutEnable)
        else $error("outputs stayed active through stop");

    wake_output_a: assert property ( // [RQ11]
        powerDownExit |=> !compEnable && !bandgapSelect &&
            !pinOutEnable && !comparatorOutputLevel)
        else $error("power-down exit left outputs active");

    cover_rise_c: cover property (
        edges.eventPulse && edgeModeSelect == comparator_pkg::MODE_RISE);
    cover_both_c: cover property (
        edges.eventPulse && edgeModeSelect == comparator_pkg::MODE_BOTH);
    cover_clear_c: cover property (
        compareEventFlag && clearFlag ##1 !compareEventFlag);
    cover_irq_c: cover property (interruptRequest ##1 !interruptRequest);
    cover_stop_c: cover property (stopMode ##1 !stopMode);
endmodule : analog_comparator_control

/* bench/comparator_model.sv */
// behavioural model of the analog comparator circuit
`timescale 1ns/1ns
module comparator_model #(
    parameter logic [11:0] BANDGAP_MV = 12'h4B0
) (
    // analog inputs in millivolts
    input wire logic [11:0] positiveMv,
    input wire logic [11:0] negativeMv,
    // control from the block
    input wire logic compEnable,
    input wire logic bandgapSelect,
    // comparator output
    output logic compRaw
);
    logic [11:0] plusMv;
    logic lastLevel;
    assign plusMv = bandgapSelect ? BANDGAP_MV : positiveMv;
    initial lastLevel = 1'b0;
    // high above, low below; equal inputs keep the old level
    always @(plusMv or negativeMv or compEnable) begin
        if (compEnable && plusMv > negativeMv) lastLevel = 1'b1;
        else if (compEnable && plusMv < negativeMv) lastLevel = 1'b0;
    end
    // unpowered circuit output is not trustworthy
    assign compRaw = compEnable ? lastLevel : ~lastLevel;
endmodule : comparator_model

/* bench/analog_comparator_control_bench.sv */
// register level tests of the comparator control block
`timescale 1ns/1ns
module analog_comparator_control_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic [7:0] writeData = 8'h00;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [7:0] readData;
    logic stopMode = 1'b0;
    logic powerDownExit = 1'b0;
    logic compRaw, compEnable, bandgapSelect;
    logic comparatorOutputPin, pinOutEnable, interruptRequest;
    logic [11:0] positiveMv = 12'h1F4;
    logic [11:0] negativeMv = 12'h3E8;
    int failures = 0;
    int nTests = 0;
    int cycles = 0;
    logic [1:0] m;
    logic wantR, wantF;
    always #2 clock = ~clock;
    analog_comparator_control u_dut (.clock(clock), .rst_n(rst_n),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData), .stopMode(stopMode),
        .powerDownExit(powerDownExit), .compRaw(compRaw),
        .compEnable(compEnable), .bandgapSelect(bandgapSelect),
        .comparatorOutputPin(comparatorOutputPin),
        .pinOutEnable(pinOutEnable), .interruptRequest(interruptRequest));
    comparator_model u_model (.positiveMv(positiveMv),
        .negativeMv(negativeMv), .compEnable(compEnable),
        .bandgapSelect(bandgapSelect), .compRaw(compRaw));
    task results;
        if (failures == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task checkByte(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask : checkByte
    task checkBit(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t output %b expected %b", $time, got,
                exp);
        end
    endtask : checkBit
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr
    // answer stands only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 checkByte(readData, exp);
    endtask : rd
    // lets registered outputs land before they are looked at
    task waitc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : waitc
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            results;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h0, 8'h00);
        checkBit(compEnable, 1'b0);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wantR = (m == 2'h1) || (m == 2'h3);
            wantF = (m != 2'h1);
            // settle first: enabling may disturb the synchroniser
            wr(4'h0, {6'h20, m});
            waitc(6);
            wr(4'h0, {6'h28, m});
            checkBit(compEnable, 1'b1);
            positiveMv <= 12'h5DC;
            waitc(6);
            rd(4'h0, {2'h2, wantR, 2'h1, 1'b0, m});
            wr(4'h0, {6'h28, m});
            positiveMv <= 12'h1F4;
            waitc(6);
            rd(4'h0, {2'h2, wantF, 2'h0, 1'b0, m});
        end
        wr(4'h0, 8'hB7);
        positiveMv <= 12'h5DC;
        waitc(6);
        checkBit(interruptRequest, 1'b1);
        checkBit(pinOutEnable, 1'b1);
        checkBit(comparatorOutputPin, 1'b1);
        wr(4'h0, 8'h97);
        rd(4'h0, 8'hBF);
        wr(4'h0, 8'hA3);
        rd(4'h0, 8'h8B);
        checkBit(interruptRequest, 1'b0);
        checkBit(pinOutEnable, 1'b0);
        checkBit(comparatorOutputPin, 1'b0);
        positiveMv <= 12'h1F4;
        waitc(6);
        checkBit(interruptRequest, 1'b0);
        rd(4'h0, 8'hA3);
        // bandgap above the minus pin turns the level high
        wr(4'h0, 8'hE3);
        waitc(6);
        checkBit(bandgapSelect, 1'b1);
        rd(4'h0, 8'hEB);
        wr(4'h0, 8'hA3);
        waitc(6);
        wr(4'h0, 8'hA3);
        positiveMv <= 12'h5DC;
        waitc(6);
        wr(4'h0, 8'hA3);
        stopMode <= 1'b1;
        positiveMv <= 12'h1F4;
        waitc(6);
        checkBit(compEnable, 1'b0);
        rd(4'h0, 8'h83);
        @(posedge clock);
        stopMode <= 1'b0;
        waitc(6);
        rd(4'h0, 8'h83);
        wr(4'h0, 8'h03);
        positiveMv <= 12'h5DC;
        waitc(6);
        rd(4'h0, 8'h03);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h03);
        wr(4'h0, 8'hD7);
        @(posedge clock);
        powerDownExit <= 1'b1;
        @(posedge clock);
        powerDownExit <= 1'b0;
        waitc(2);
        checkBit(compEnable, 1'b0);
        checkBit(bandgapSelect, 1'b0);
        rd(4'h0, 8'h00);
        results;
    end
endmodule : analog_comparator_control_bench
